// File: pvic_top.sv
// Parallel I/O unit with the access state machine, port B vectored interrupt
// controller and port C board control bits.
// Assumes host strobes are synchronous one-cycle pulses and that the vector
// acknowledge strobe arrives only while the interrupt request is pending.
//
// Notes on behaviour
// - Data port accesses never change the access state; only control port does.
// - Three states: reset while board reset active, then state 0 and state 1.
// - State 0 control read returns pointed register, stays in state 0.
// - State 0 control write loads the pointer and moves to state 1.
// - State 1 control read or write accesses pointed register, back to state 0.
// - State 1 suspends interrupt request and acknowledge handling.
// - Port B bit port, or-priority encoded vector matching, D7 highest.
// - Port B bit n is vectored interrupt line 7 minus n.
// - Port B inputs non-inverting, each with a ones catcher.
// - Polarity, transition and mask bits decide each line's match condition.
// - Polarity ones, transition zero, mask D6 only: high D6 is active.
// - A mask bit of one enables that line; a high held by the ones catcher counts active with polarity one and transition zero.
// - Match requests interrupt; acknowledge returns vector with top bit in D3-D1.
// - Port C enabled, non-inverting; D3, D2, D0 outputs, D1 input.
// - Pattern mask sits at pointer 2f; its D7 enables line zero.
module pvic_top
(
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       rd_i,
    input  wire logic       wr_i,
    output logic      [7:0] rdata_o,
    input  wire logic [7:0] port_b_i,
    input  wire logic       port_c_i,
    output logic      [3:0] port_c_o,
    output logic      [3:0] port_c_oe_o,
    output logic            irq_o,
    input  wire logic       intack_i,
    output logic      [7:0] vector_o,
    output logic      [1:0] access_state_o
);
    import pvic_pkg::*;

    // =====================================================================
    // Declarations
    pvic_state_t state;
    pvic_state_t next_state;
    logic [7:0]  pointer;
    logic [7:0]  irq_ctl;
    logic [7:0]  cfg_ctl;
    logic [7:0]  b_vector;
    logic [7:0]  b_pol;
    logic [7:0]  b_trn;
    logic [7:0]  b_mask;
    logic [7:0]  catcher;
    logic [7:0]  b_prev;
    logic        b_ie;
    logic        b_ip;
    logic [3:0]  c_out;
    logic        ctrl_sel;
    logic        reg_rd;
    logic        reg_wr;
    logic [7:0]  match;
    logic        any_match;
    logic [7:0]  reg_rdata;
    logic [7:0]  next_rdata;
    logic        run_ok;

    // Highest set bit number, D7 first
    function automatic logic [2:0] top_bit(input logic [7:0] v);
        logic [2:0] n;
        n = 3'd0;
        for (int i = 0; i < 8; i++)
        begin
            if (v[i])
            begin
                n = 3'(i);
            end
        end
        return n;
    endfunction

    // =====================================================================
    // Access strobes
    assign ctrl_sel = (addr_i == PVIC_CTRL_ADDR);
    assign reg_rd   = ctrl_sel && rd_i;
    assign reg_wr   = ctrl_sel && wr_i && (state == PVIC_ST_1);
    assign run_ok   = (state == PVIC_ST_0) && !irq_ctl[PVIC_IRQ_RESET_BIT];

    // Next access state
    always_comb
    begin
        next_state = state;
        unique case (state)
            PVIC_ST_RESET:
            begin
                next_state = PVIC_ST_0;
            end
            PVIC_ST_0:
            begin
                if (ctrl_sel && wr_i)
                begin
                    next_state = PVIC_ST_1;
                end
            end
            PVIC_ST_1:
            begin
                if (ctrl_sel && (rd_i || wr_i))
                begin
                    next_state = PVIC_ST_0;
                end
            end
            default:
            begin
                next_state = PVIC_ST_RESET;
            end
        endcase
    end

    // Access state register
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            state <= PVIC_ST_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Register pointer
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            pointer <= PVIC_ZERO_RST;
        end
        else if (ctrl_sel && wr_i && state == PVIC_ST_0)
        begin
            pointer <= wdata_i;
        end
    end

    // =====================================================================
    // Writable control registers
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            irq_ctl  <= PVIC_IRQ_CTL_RST;
            cfg_ctl  <= PVIC_CFG_CTL_RST;
            b_vector <= PVIC_ZERO_RST;
            b_pol    <= PVIC_POL_RST;
            b_trn    <= PVIC_ZERO_RST;
            b_mask   <= PVIC_ZERO_RST;
            b_ie     <= 1'b0;
        end
        else if (reg_wr)
        begin
            unique case (pointer)
                PVIC_REG_IRQ_CTL:  irq_ctl  <= wdata_i;
                PVIC_REG_CFG_CTL:  cfg_ctl  <= wdata_i;
                PVIC_REG_B_VECTOR: b_vector <= wdata_i;
                PVIC_REG_B_POL:    b_pol    <= wdata_i;
                PVIC_REG_B_TRN:    b_trn    <= wdata_i;
                PVIC_REG_B_MASK:   b_mask   <= wdata_i;
                PVIC_REG_B_CS:     b_ie     <= wdata_i[PVIC_CS_IE_BIT];
                default:           b_ie     <= b_ie;
            endcase
        end
    end

    // =====================================================================
    // Port B ones catchers; set wins over software clear
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            catcher <= PVIC_ZERO_RST;
            b_prev  <= PVIC_ZERO_RST;
        end
        else
        begin
            b_prev <= port_b_i;
            if (wr_i && addr_i == PVIC_DATA_B_ADDR)
            begin
                catcher <= (catcher & ~wdata_i) | port_b_i;
            end
            else
            begin
                catcher <= catcher | port_b_i;
            end
        end
    end

    // Pattern match per line: transition or level against polarity
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (b_trn[i])
            begin
                match[i] = b_mask[i] && (port_b_i[i] != b_prev[i])
                           && (port_b_i[i] == b_pol[i]);
            end
            else if (b_pol[i])
            begin
                match[i] = b_mask[i] && catcher[i];
            end
            else
            begin
                match[i] = b_mask[i] && !port_b_i[i];
            end
        end
    end
    assign any_match = cfg_ctl[PVIC_CFG_B_EN_BIT] && (|match);

    // Interrupt pending, suspended in state 1; set wins over clear
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            b_ip <= 1'b0;
        end
        else if (run_ok && any_match)
        begin
            b_ip <= 1'b1;
        end
        else if (reg_wr && pointer == PVIC_REG_B_CS && wdata_i[PVIC_CS_CLR_BIT])
        begin
            b_ip <= 1'b0;
        end
    end

    // Vector with top matching bit number in D3-D1
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            vector_o <= PVIC_ZERO_RST;
        end
        else if (intack_i && run_ok)
        begin
            vector_o <= {b_vector[7:4], top_bit(match), b_vector[0]};
        end
    end

    assign irq_o = b_ip && b_ie && irq_ctl[PVIC_IRQ_MIE_BIT] && run_ok;

    // =====================================================================
    // Port C: D1 input, others outputs when enabled
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            c_out <= PVIC_C_OUT_RST;
        end
        else if (wr_i && addr_i == PVIC_DATA_C_ADDR)
        begin
            c_out <= wdata_i[3:0] & ~PVIC_C_DIR_MASK;
        end
    end
    assign port_c_o    = c_out;
    assign port_c_oe_o = cfg_ctl[PVIC_CFG_C_EN_BIT] ? ~PVIC_C_DIR_MASK : 4'h0;

    // =====================================================================
    // Read data
    always_comb
    begin
        unique case (pointer)
            PVIC_REG_IRQ_CTL:  reg_rdata = irq_ctl;
            PVIC_REG_CFG_CTL:  reg_rdata = cfg_ctl;
            PVIC_REG_B_VECTOR: reg_rdata = b_vector;
            PVIC_REG_B_POL:    reg_rdata = b_pol;
            PVIC_REG_B_TRN:    reg_rdata = b_trn;
            PVIC_REG_B_MASK:   reg_rdata = b_mask;
            PVIC_REG_B_CS:     reg_rdata = {b_ie, 1'b0, b_ip, 5'h00};
            default:           reg_rdata = PVIC_ZERO_RST;
        endcase
    end

    always_comb
    begin
        next_rdata = PVIC_ZERO_RST;
        if (reg_rd)
        begin
            next_rdata = reg_rdata;
        end
        else if (rd_i && addr_i == PVIC_DATA_B_ADDR)
        begin
            next_rdata = port_b_i;
        end
        else if (rd_i && addr_i == PVIC_DATA_C_ADDR)
        begin
            next_rdata = {4'h0, c_out[3:2], port_c_i, c_out[0]};
        end
    end

    // Registered read data, valid the cycle after the read strobe
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            rdata_o <= PVIC_ZERO_RST;
        end
        else
        begin
            rdata_o <= next_rdata;
        end
    end

    assign access_state_o = {state == PVIC_ST_1, state == PVIC_ST_0};

endmodule // pvic_top

// File: pvic_pkg.sv
// Package for the parallel I/O vectored interrupt unit: addresses, register
// pointers, field positions and reset values.
// Assumes an 8-bit I/O space and a host that drives one access per strobe.
package pvic_pkg;

    // =====================================================================
    // Port addresses
    localparam logic [7:0] PVIC_DATA_A_ADDR = 8'h78;
    localparam logic [7:0] PVIC_DATA_B_ADDR = 8'h79;
    localparam logic [7:0] PVIC_DATA_C_ADDR = 8'h7A;
    localparam logic [7:0] PVIC_CTRL_ADDR   = 8'h7B;

    // =====================================================================
    // Internal register pointers
    localparam logic [7:0] PVIC_REG_IRQ_CTL  = 8'h00;
    localparam logic [7:0] PVIC_REG_CFG_CTL  = 8'h01;
    localparam logic [7:0] PVIC_REG_B_VECTOR = 8'h02;
    localparam logic [7:0] PVIC_REG_B_CS     = 8'h09;
    localparam logic [7:0] PVIC_REG_B_POL    = 8'h2D;
    localparam logic [7:0] PVIC_REG_B_TRN    = 8'h2E;
    localparam logic [7:0] PVIC_REG_B_MASK   = 8'h2F;

    // =====================================================================
    // Field positions
    localparam int PVIC_IRQ_MIE_BIT   = 7;
    localparam int PVIC_IRQ_RESET_BIT = 0;
    localparam int PVIC_CFG_B_EN_BIT  = 7;
    localparam int PVIC_CFG_C_EN_BIT  = 4;
    localparam int PVIC_CS_IE_BIT     = 7;
    localparam int PVIC_CS_IP_BIT     = 5;
    localparam int PVIC_CS_CLR_BIT    = 4;

    // =====================================================================
    // Reset values and port C direction mask
    localparam logic [7:0] PVIC_IRQ_CTL_RST  = 8'h01;
    localparam logic [7:0] PVIC_CFG_CTL_RST  = 8'h00;
    localparam logic [7:0] PVIC_ZERO_RST     = 8'h00;
    localparam logic [7:0] PVIC_POL_RST      = 8'h00;
    localparam logic [3:0] PVIC_C_OUT_RST    = 4'h0;
    localparam logic [3:0] PVIC_C_DIR_MASK   = 4'h2;

    // =====================================================================
    // Access state machine
    typedef enum logic [2:0]
    {
        PVIC_ST_RESET = 3'b001,
        PVIC_ST_0     = 3'b010,
        PVIC_ST_1     = 3'b100
    } pvic_state_t;

endpackage : pvic_pkg

// File: pvic_monitor.sv
// Checker for the vectored interrupt unit: access states, irq hold, port C.
// Sees only the top ports; bound from the bench top.
module pvic_monitor
(
    input wire logic       clk_sys_i,
    input wire logic       resetn_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       rd_i,
    input wire logic       wr_i,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] port_b_i,
    input wire logic       port_c_i,
    input wire logic [3:0] port_c_o,
    input wire logic [3:0] port_c_oe_o,
    input wire logic       irq_o,
    input wire logic       intack_i,
    input wire logic [7:0] vector_o,
    input wire logic [1:0] access_state_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import pvic_pkg::*;
    // ==========
    // Access steps
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    sequence ptr_load_s;
        wr_i && addr_i == PVIC_CTRL_ADDR && access_state_o == 2'b01;
    endsequence
    sequence s1_write_s;
        wr_i && addr_i == PVIC_CTRL_ADDR && access_state_o == 2'b10;
    endsequence
    sequence data_acc_s;
        (rd_i || wr_i) && addr_i inside {[8'h78:8'h7A]};
    endsequence
    // ==========
    // Assertions
    data_port_a: assert property (data_acc_s |=> $stable(access_state_o))
        else $error("state moved on data port access");
    reset_state_a: assert property (disable iff (1'b0) !resetn_i |=> access_state_o == 2'b00)
        else $error("state not reset");
    state_legal_a: assert property ($past(resetn_i) |-> access_state_o inside {2'b01, 2'b10})
        else $error("illegal access state");
    ptr_load_a: assert property (ptr_load_s |=> access_state_o == 2'b10)
        else $error("pointer write did not reach state 1");
    s1_return_a: assert property (s1_write_s |=> access_state_o == 2'b01)
        else $error("state 1 write did not return");
    ctl_read_a: assert property (rd_i && addr_i == PVIC_CTRL_ADDR |=> access_state_o == 2'b01)
        else $error("control read left state 1");
    s1_quiet_a: assert property (access_state_o == 2'b10 |-> !irq_o)
        else $error("irq in state 1");
    vector_hold_a: assert property (!(intack_i && access_state_o == 2'b01) |=> $stable(vector_o))
        else $error("vector changed without ack");
    irq_hold_a: assert property (irq_o && !wr_i |=> irq_o)
        else $error("irq dropped without write");
    port_c_dir_a: assert property (port_c_oe_o != 4'h0 |-> port_c_oe_o == 4'b1101 && !port_c_o[1])
        else $error("port C direction wrong");
endmodule // pvic_monitor

// File: pvic_host_model.sv
// Host processor model issuing I/O reads and writes, one strobe per access.
// Driven from the bench by hierarchical task calls; changes lines at falling edges.
module pvic_host_model
(
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] rdata_i,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            rd_o,
    output logic            wr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial
    begin
        addr_o  = 8'h00;
        wdata_o = 8'h00;
        rd_o    = 1'b0;
        wr_o    = 1'b0;
    end
    // One access; sequences run in one process, never interleaved
    task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
        @(negedge clk_sys_i);
        addr_o  = a;
        wdata_o = d;
        wr_o    = w;
        rd_o    = !w;
        @(negedge clk_sys_i);
        q       = rdata_i;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        addr_o  = ~a; // Released bus shows no stale value
        wdata_o = ~d;
    endtask
endmodule // pvic_host_model

// File: tb_top.sv
// Bench for the vectored interrupt unit: states, pattern irq, vector, port C.
// Needs pvic_pkg, pvic_top, pvic_host_model and pvic_monitor.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pvic_pkg::*;
    logic       clk_sys_i = 1'b0;
    logic       resetn_i  = 1'b0;
    logic [7:0] addr_w, wdata_w, rdata_w, vector_w, q;
    logic [7:0] port_b_w  = 8'h00;
    logic       intack_w  = 1'b0;
    logic       rd_w, wr_w, irq_w;
    logic [3:0] c_out_w, c_oe_w;
    logic [1:0] state_w;
    int         err_total = 0;
    int         check_count = 0;
    // Clock and units
    always #10 clk_sys_i = ~clk_sys_i;
    pvic_host_model i_host (.clk_sys_i, .rdata_i(rdata_w), .addr_o(addr_w),
        .wdata_o(wdata_w), .rd_o(rd_w), .wr_o(wr_w));
    pvic_top i_dut (.clk_sys_i, .resetn_i, .addr_i(addr_w), .wdata_i(wdata_w),
        .rd_i(rd_w), .wr_i(wr_w), .rdata_o(rdata_w), .port_b_i(port_b_w),
        .port_c_i(1'b0), .port_c_o(c_out_w), .port_c_oe_o(c_oe_w), .irq_o(irq_w),
        .intack_i(intack_w), .vector_o(vector_w), .access_state_o(state_w));
    // Checking and closing
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task test_done;
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Register access in pairs through the control port
    task reg_wr(input logic [7:0] p, input logic [7:0] v);
        i_host.io(1'b1, PVIC_CTRL_ADDR, p, q);
        i_host.io(1'b1, PVIC_CTRL_ADDR, v, q);
    endtask
    task reg_rd(input logic [7:0] p);
        i_host.io(1'b1, PVIC_CTRL_ADDR, p, q);
        i_host.io(1'b0, PVIC_CTRL_ADDR, 8'h00, q);
    endtask
    task pulse_b(input logic [7:0] v);
        @(negedge clk_sys_i);
        port_b_w = v;
        @(negedge clk_sys_i);
        port_b_w = 8'h00;
        repeat (3) @(negedge clk_sys_i);
    endtask
    task ack;
        @(negedge clk_sys_i);
        intack_w = 1'b1;
        @(negedge clk_sys_i);
        intack_w = 1'b0;
    endtask
    // Scenarios
    task t_reset;
        chk({6'h00, state_w}, 8'h01);
        i_host.io(1'b0, PVIC_CTRL_ADDR, 8'h00, q);
        reg_rd(PVIC_REG_IRQ_CTL);
        chk(q, PVIC_IRQ_CTL_RST);
        reg_rd(PVIC_REG_CFG_CTL);
        chk(q, PVIC_CFG_CTL_RST);
    endtask
    task t_states;
        i_host.io(1'b1, PVIC_CTRL_ADDR, PVIC_REG_B_MASK, q);
        chk({6'h00, state_w}, 8'h02);
        i_host.io(1'b0, PVIC_DATA_A_ADDR, 8'h00, q);
        i_host.io(1'b1, PVIC_DATA_B_ADDR, 8'hFF, q);
        chk({6'h00, state_w}, 8'h02);
        i_host.io(1'b1, PVIC_CTRL_ADDR, 8'hC0, q);
        chk({6'h00, state_w}, 8'h01);
        reg_rd(PVIC_REG_B_MASK);
        chk(q, 8'hC0);
        reg_rd(8'h3F);
        chk(q, 8'h00);
    endtask
    task t_irq;
        reg_wr(PVIC_REG_CFG_CTL, 8'h10);
        reg_wr(PVIC_REG_B_MASK, 8'h40);
        reg_wr(PVIC_REG_CFG_CTL, 8'h90);
        reg_wr(PVIC_REG_B_POL, 8'hFF);
        reg_wr(PVIC_REG_B_TRN, 8'h00);
        reg_wr(PVIC_REG_B_VECTOR, 8'h51);
        reg_wr(PVIC_REG_B_CS, 8'h80);
        reg_wr(PVIC_REG_IRQ_CTL, 8'h80);
        i_host.io(1'b1, PVIC_DATA_B_ADDR, 8'hFF, q);
        pulse_b(8'h80);
        chk({7'h00, irq_w}, 8'h00);
        pulse_b(8'h40);
        chk({7'h00, irq_w}, 8'h01);
        ack;
        chk(vector_w, 8'h5D);
        i_host.io(1'b1, PVIC_CTRL_ADDR, 8'h00, q);
        chk({7'h00, irq_w}, 8'h00);
        i_host.io(1'b0, PVIC_CTRL_ADDR, 8'h00, q);
        chk({7'h00, irq_w}, 8'h01);
        reg_wr(PVIC_REG_CFG_CTL, 8'h10);
        reg_wr(PVIC_REG_B_MASK, 8'hC0);
        reg_wr(PVIC_REG_CFG_CTL, 8'h90);
        ack;
        chk(vector_w, 8'h5F);
        i_host.io(1'b1, PVIC_DATA_B_ADDR, 8'hFF, q);
        reg_wr(PVIC_REG_B_CS, 8'h90);
        chk({7'h00, irq_w}, 8'h00);
    endtask
    task t_port_c;
        chk({4'h0, c_oe_w}, 8'h0D);
        i_host.io(1'b1, PVIC_DATA_C_ADDR, 8'h08, q);
        chk({4'h0, c_out_w}, 8'h08);
        i_host.io(1'b1, PVIC_DATA_C_ADDR, 8'h0F, q);
        chk({4'h0, c_out_w}, 8'h0D);
    endtask
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        err_total++;
        test_done;
    end
    // Main sequence
    initial
    begin
        repeat (20) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        t_reset;
        t_states;
        t_irq;
        t_port_c;
        test_done;
    end
endmodule // tb_top

bind pvic_top pvic_monitor i_mon (.clk_sys_i, .resetn_i, .addr_i, .wdata_i, .rd_i, .wr_i,
    .rdata_o, .port_b_i, .port_c_i, .port_c_o, .port_c_oe_o, .irq_o, .intack_i, .vector_o,
    .access_state_o);
